// ===== rtl/cbfc_ctrl.sv
`default_nettype none
module cbfc_skid #(
	parameter int W = 9,
	parameter int D = 4
) (
	input  wire logic         i_ref_clk, // System clock
	input  wire logic         i_nrst,    // Sync reset, low
	input  wire logic         i_valid,   // Source offers
	output logic              o_ready,   // Room left
	input  wire logic [W-1:0] i_data,    // Source word
	output logic              o_valid,   // Word held
	input  wire logic         i_ready,   // Drain takes
	output logic [W-1:0]      o_data     // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp;
	logic [AW:0]  rp;
	wire logic    push = i_valid & o_ready;
	wire logic    pop  = o_valid & i_ready;
	assign o_ready = (wp - rp) != (AW+1)'(D);
	assign o_valid = wp != rp;
	assign o_data  = mem[rp[AW-1:0]];
	always_ff @(posedge i_ref_clk)
	begin
		if (push)
			mem[wp[AW-1:0]] <= i_data;
	end
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			wp <= '0;
			rp <= '0;
		end
		else
		begin
			wp <= push ? wp + 1'b1 : wp;
			rp <= pop ? rp + 1'b1 : rp;
		end
	end
endmodule : cbfc_skid

module cbfc_ctrl import cbfc_pkg::*; #(
	parameter int   AW       = CBFC_AW_DEF,
	parameter logic TX_RESET = 1'b0
) (
	input  wire logic        i_ref_clk,    // System clock
	input  wire logic        i_nrst,       // Sync reset, low
	input  wire logic [15:0] i_fifo_base,  // Buffer base location
	input  wire logic        i_cs,         // Bus access this cycle
	input  wire logic        i_we,         // Write when high
	input  wire logic [7:0]  i_addr,       // Byte address
	input  wire logic [1:0]  i_size,       // Bytes minus one
	input  wire logic [31:0] i_wdata,      // Write data, big endian
	output logic [31:0]      o_rdata,      // Read data
	output logic             o_ack,        // Access done
	input  wire logic        i_per_wvalid, // Peripheral byte offered
	output logic             o_per_wready, // Peripheral byte taken
	input  wire logic [7:0]  i_per_wdata,  // Peripheral byte
	input  wire logic        i_per_weof,   // Last byte of frame
	output logic             o_per_rvalid, // Byte for peripheral
	input  wire logic        i_per_rready, // Peripheral takes byte
	output logic [7:0]       o_per_rdata,  // Byte to peripheral
	output logic             o_per_reof,   // Byte ends a frame
	output logic             o_alarm,      // Threshold alarm
	output logic             o_frame_ready,// Complete frame held
	output logic             o_dma_req,    // Service request
	output logic [15:0]      o_rd_phys     // Next read location
);
	localparam int          D      = 1 << AW;
	localparam logic [AW-1:0] THR_TX = {2'b00, {(AW-2){1'b1}}};
	localparam logic        ALARM_RST = TX_RESET ? ALARM_RST_TX : ALARM_RST_RX;
	localparam logic [AW-1:0] THR_RST = TX_RESET ? THR_TX : '0;

	logic [8:0]    mem [D];
	logic [AW:0]   wp;
	logic [AW:0]   rp;
	logic [AW:0]   frames;
	logic [AW-1:0] thr;
	logic [2:0]    gr;
	logic          frame_en;
	logic          tx;
	logic          wr_frame;
	logic          req_en;
	logic          alarm;
	logic          st_illegal;
	logic          st_stall;
	logic [31:0]   status_v;
	logic [31:0]   control_v;

	wire logic [AW:0] used = wp - rp;
	wire logic [AW:0] free = (AW+1)'(D) - used;

	wire logic       sel_data = i_cs && i_addr[7:2] == OFF_DATA[7:2];
	wire logic [1:0] off      = i_addr[1:0];
	wire logic [2:0] nb       = {1'b0, i_size} + 3'h1;
	wire logic [2:0] end_lane = {1'b0, off} + nb;
	wire logic legal = (i_size == SZ_BYTE) || (i_size == SZ_WORD && !off[0])
		|| (off == 2'h0);
	wire logic bus_rd   = sel_data && !i_we && legal;
	wire logic bus_wr   = sel_data && i_we && legal;
	wire logic rd_short = used < (AW+1)'(nb);
	wire logic wr_short = free < (AW+1)'(nb);
	wire logic stall    = (bus_rd && rd_short) || (bus_wr && wr_short);
	// data port open in either direction
	wire logic do_rd    = bus_rd && !rd_short;
	wire logic do_wr    = bus_wr && !wr_short;
	wire logic wr_reg   = i_cs && i_we && !sel_data;
	wire logic wr_stat  = wr_reg && i_addr == OFF_STATUS;
	wire logic wr_ctrl  = wr_reg && i_addr == OFF_CONTROL;
	wire logic wr_thr   = wr_reg && i_addr == OFF_THRESH;
	wire logic wr_rdp   = wr_reg && i_addr == OFF_READ_LOCATION_POINTER;

	// single cycle unless short of bytes
	assign o_ack = i_cs && !stall;

	logic [AW:0] lane_rptr [4];
	logic [AW:0] lane_wptr [4];
	logic [8:0]  lane_q [4];
	logic [3:0]  in_lane;
	logic [3:0]  rd_eof;
	logic [31:0] rd_bytes;
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		// lane g is byte g of the big-endian word
		assign in_lane[g]   = 3'(g) >= {1'b0, off} && 3'(g) < end_lane;
		assign lane_rptr[g] = rp + (AW+1)'(2'(g) - off);
		assign lane_wptr[g] = wp + (AW+1)'(2'(g) - off);
		assign lane_q[g]    = mem[lane_rptr[g][AW-1:0]];
		assign rd_bytes[31-8*g -: 8] = in_lane[g] ? lane_q[g][7:0] : 8'h00;
		assign rd_eof[g]    = do_rd && in_lane[g] && lane_q[g][8];
	end

	// Peripheral side: receive fills via skid buffer, transmit drains
	logic       sk_valid;
	logic [8:0] sk_data;
	wire logic  sk_ready = !tx && free != '0 && !do_wr;
	wire logic  per_push = sk_valid && sk_ready;
	assign o_per_rvalid = tx && used != '0 && !do_rd;
	assign o_per_rdata  = mem[rp[AW-1:0]][7:0];
	assign o_per_reof   = mem[rp[AW-1:0]][8];
	wire logic  per_pop  = o_per_rvalid && i_per_rready;

	cbfc_skid #(
		.W (9),
		.D (CBFC_SKID_DEPTH)
	) u_skid (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_valid   (i_per_wvalid),
		.o_ready   (o_per_wready),
		.i_data    ({i_per_weof, i_per_wdata}),
		.o_valid   (sk_valid),
		.i_ready   (sk_ready),
		.o_data    (sk_data)
	);

	// Frame markers travel in bit 8 of each stored byte
	wire logic [2:0] push_eofs = 3'(do_wr && wr_frame) + 3'(per_push && sk_data[8]);
	wire logic [2:0] pop_eofs  = 3'(rd_eof[0]) + 3'(rd_eof[1]) + 3'(rd_eof[2])
		+ 3'(rd_eof[3]) + 3'(per_pop && o_per_reof);
	// frame ready while whole frames held
	assign o_frame_ready = frame_en && frames != '0;

	wire logic set_c = tx ? used <= {1'b0, thr} : free <= {1'b0, thr};
	wire logic clr_c = tx ? free < (AW+1)'({gr, 2'b00}) : used < (AW+1)'(gr);
	wire logic hold  = !tx && o_frame_ready;
	// alarm holds between set and clear points
	wire logic next_alarm = set_c || (alarm && !(clr_c && !hold));

	wire logic [AW:0] next_rp = do_rd ? rp + (AW+1)'(nb) : per_pop ? rp + 1'b1
		: wr_rdp ? {rp[AW], i_wdata[AW-1:0]} : rp;
	wire logic [AW:0] next_wp = do_wr ? wp + (AW+1)'(nb) : per_push ? wp + 1'b1 : wp;

	always_ff @(posedge i_ref_clk)
	begin
		for (int k = 0; k < 4; k++)
			if (do_wr && in_lane[k])
				mem[lane_wptr[k][AW-1:0]] <= {wr_frame && 3'(k) == end_lane - 3'h1,
					i_wdata[31-8*k -: 8]};
		if (per_push)
			mem[wp[AW-1:0]] <= sk_data;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			rp         <= '0;
			wp         <= '0;
			frames     <= '0;
			thr        <= THR_RST;
			alarm      <= ALARM_RST;
			tx         <= TX_RESET;
			gr         <= GR_RST;
			frame_en   <= 1'b0;
			wr_frame   <= 1'b0;
			req_en     <= REQ_EN_RST;
			st_illegal <= 1'b0;
			st_stall   <= 1'b0;
		end
		else
		begin
			rp     <= next_rp;
			wp     <= next_wp;
			frames <= frames + (AW+1)'(push_eofs) - (AW+1)'(pop_eofs);
			alarm  <= next_alarm;
			if (wr_thr)
				thr <= i_wdata[AW-1:0];
			if (wr_ctrl)
			begin
				gr       <= i_wdata[CT_GR_LSB +: 3];
				frame_en <= i_wdata[CT_FRAME_EN];
				tx       <= i_wdata[CT_TX];
				req_en   <= i_wdata[CT_REQ_EN];
			end
			// One-shot: marks the last byte of the next data write
			wr_frame <= wr_ctrl ? i_wdata[CT_WR_FRAME] : wr_frame && !do_wr;
			// write one clears, a new event wins
			st_illegal <= (sel_data && !legal)
				|| (st_illegal && !(wr_stat && i_wdata[ST_ILLEGAL]));
			st_stall   <= stall || (st_stall && !(wr_stat && i_wdata[ST_STALL]));
		end
	end

	always_comb
	begin
		status_v                 = '0;
		status_v[ST_EMPTY]       = used == '0;
		status_v[ST_ALARM]       = alarm;
		status_v[ST_FULL]        = free == '0;
		status_v[ST_FRAME_READY] = o_frame_ready;
		status_v[ST_ILLEGAL]     = st_illegal;
		status_v[ST_STALL]       = st_stall;
		control_v                = '0;
		control_v[CT_GR_LSB +: 3] = gr;
		control_v[CT_FRAME_EN]   = frame_en;
		control_v[CT_TX]         = tx;
		control_v[CT_WR_FRAME]   = wr_frame;
		control_v[CT_REQ_EN]     = req_en;
	end

	assign o_rdata = sel_data ? rd_bytes
		: i_addr == OFF_STATUS ? status_v
		: i_addr == OFF_CONTROL ? control_v
		: i_addr == OFF_THRESH ? {(32-AW)'(0), thr}
		: i_addr == OFF_READ_LOCATION_POINTER ? {(32-AW)'(0), rp[AW-1:0]} : 32'h0;

	assign o_alarm   = alarm;
	assign o_dma_req = alarm && req_en;
	assign o_rd_phys = i_fifo_base + 16'(rp[AW-1:0]);

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_reg_acc;
		i_cs && !sel_data;
	endsequence
	sequence s_b2b;
		s_reg_acc ##1 s_reg_acc;
	endsequence
	property p_misaligned_flag;
		sel_data && i_size == SZ_TRI && off != 2'h0 |=> st_illegal;
	endproperty
	a_misaligned_flag: assert property (p_misaligned_flag) else $error("bad 24-bit not flagged");
	property p_word_at_two;
		sel_data && !i_we && i_size == SZ_WORD && off == 2'h2 && used >= 2
			|-> o_ack && o_rdata[31:16] == 16'h0;
	endproperty
	a_word_at_two: assert property (p_word_at_two) else $error("word at two refused");
	property p_no_wait;
		sel_data && !i_we && i_size == SZ_LONG && off == 2'h0 && used >= 4 |-> o_ack;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("read waited with data");
	property p_sticky;
		st_illegal && !(wr_stat && i_wdata[ST_ILLEGAL]) |=> st_illegal;
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky flag lost");
	property p_reset_vals;
		!$past(i_nrst) |-> alarm == ALARM_RST && thr == THR_RST && rp == '0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
	property p_tx_set;
		tx && used <= {1'b0, thr} |=> o_alarm;
	endproperty
	a_tx_set: assert property (p_tx_set) else $error("tx alarm not set");
	property p_rx_set;
		!tx && free <= {1'b0, thr} |=> o_alarm;
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("rx alarm not set");
	property p_tx_hold;
		tx && alarm && free >= (AW+1)'({gr, 2'b00}) |=> o_alarm;
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx alarm dropped early");
	property p_frame_hold;
		!tx && alarm && o_frame_ready |=> o_alarm;
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame hold failed");
	property p_frame_in;
		frame_en && push_eofs != 3'h0 && pop_eofs == 3'h0 && !wr_ctrl |=> o_frame_ready;
	endproperty
	a_frame_in: assert property (p_frame_in) else $error("frame ready missing");
	property p_advance;
		do_rd |=> rp == $past(rp) + (AW+1)'($past(nb));
	endproperty
	a_advance: assert property (p_advance) else $error("read pointer step wrong");
	property p_b2b;
		s_b2b |-> o_ack && $past(o_ack);
	endproperty
	a_b2b: assert property (p_b2b) else $error("back to back not served");
endmodule : cbfc_ctrl
`default_nettype wire

// ===== include/cbfc_pkg.sv
// Operation
// - Data port takes byte, word, longword; 24-bit only at base offset.
// - Bytes at offsets one to three and words at offset two are accepted.
// - Data port reads and writes work in both transmit and receive direction.
// - Reads finish without wait; stall only when too few bytes are held.
// - Sticky flags clear on writing one; writing zero leaves them.
// - Alarm resets to zero for receive, one for transmit.
// - Transmit alarm sets when held bytes are at or below threshold.
// - Receive alarm sets when empty bytes are at or below threshold.
// - Set alarm holds until level passes the granularity deassertion point.
// - Transmit alarm clears when free bytes drop below four times granularity.
// - Receive alarm clears when held bytes drop below granularity.
// - Threshold is at most twelve bits; unimplemented bits read zero.
// - Threshold resets to zero for receive; transmit sets all but two top bits.
// - With frame mode on, a completed frame in the buffer sets frame ready.
// - Frame ready holds the receive request until the frame is removed.
// - Physical read location is read pointer plus supplied base.
// - Read pointer is twelve bits, software read/write, resets to zero.
// - Programmable request output drives the DMA engine.
// - Every register access, back to back too, is served in one cycle; data accesses wait while short of bytes.
`default_nettype none
package cbfc_pkg;
	localparam int          CBFC_AW_DEF     = 12;
	localparam int          CBFC_SKID_DEPTH = 4;
	localparam logic [7:0]  OFF_DATA        = 8'h00;
	localparam logic [7:0]  OFF_STATUS      = 8'h04;
	localparam logic [7:0]  OFF_CONTROL     = 8'h08;
	localparam logic [7:0]  OFF_THRESH      = 8'h0c;
	localparam logic [7:0]  OFF_READ_LOCATION_POINTER       = 8'h10;
	localparam int          ST_EMPTY        = 0;
	localparam int          ST_ALARM        = 1;
	localparam int          ST_FULL         = 2;
	localparam int          ST_FRAME_READY  = 3;
	localparam int          ST_ILLEGAL      = 4;
	localparam int          ST_STALL        = 5;
	localparam int          CT_GR_LSB       = 0;
	localparam int          CT_FRAME_EN     = 3;
	localparam int          CT_TX           = 4;
	localparam int          CT_WR_FRAME     = 5;
	localparam int          CT_REQ_EN       = 6;
	localparam logic [1:0]  SZ_BYTE         = 2'h0;
	localparam logic [1:0]  SZ_WORD         = 2'h1;
	localparam logic [1:0]  SZ_TRI          = 2'h2;
	localparam logic [1:0]  SZ_LONG         = 2'h3;
	localparam logic        ALARM_RST_TX    = 1'h1;
	localparam logic        ALARM_RST_RX    = 1'h0;
	localparam logic [2:0]  GR_RST          = 3'h0;
	localparam logic        REQ_EN_RST      = 1'h1;
endpackage : cbfc_pkg
`default_nettype wire

// ===== tb/cbfc_far_model.sv
`default_nettype none
module cbfc_far_model (
	input  wire logic       i_ref_clk, // System clock
	input  wire logic       i_nrst,    // Sync reset, low
	input  wire logic [4:0] i_cnt,     // Bytes in next burst
	input  wire logic       i_go,      // Start a burst
	input  wire logic       i_eof,     // Mark burst end as frame end
	input  wire logic       i_drain,   // Accept offered bytes
	input  wire logic       i_wready,  // Block takes byte
	input  wire logic       i_rvalid,  // Block offers byte
	input  wire logic [7:0] i_rdata,   // Offered byte
	output logic            o_wvalid,  // Byte on offer
	output logic [7:0]      o_wdata,   // Byte value
	output logic            o_weof,    // Last byte of frame
	output logic            o_rready,  // Taking bytes
	output logic [7:0]      o_taken,   // Bytes drained
	output logic [7:0]      o_last     // Last byte drained
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] left;
	logic [7:0] val;
	assign o_wvalid = left != 5'h00;
	// Idle lane shows the inverse so a stale byte never passes
	assign o_wdata  = o_wvalid ? val : ~val;
	assign o_weof   = o_wvalid && i_eof && left == 5'h01;
	assign o_rready = i_drain;
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			left    <= 5'h00;
			val     <= 8'h10;
			o_taken <= 8'h00;
		end
		else
		begin
			if (i_go)
				left <= i_cnt;
			else if (o_wvalid && i_wready)
			begin
				left <= left - 5'h01;
				val  <= val + 8'h01;
			end
			if (i_rvalid && o_rready)
			begin
				o_taken <= o_taken + 8'h01;
				o_last  <= i_rdata;
			end
		end
	end
endmodule : cbfc_far_model
`default_nettype wire

// ===== tb/cbfc_ctrl_tb.sv
`default_nettype none
module cbfc_ctrl_tb import cbfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 1'b0;
	logic        nrst      = 1'b0;
	logic        cs        = 1'b0;
	logic        we        = 1'b0;
	logic [7:0]  addr      = 8'h00;
	logic [1:0]  size      = 2'h0;
	logic [31:0] wdata     = 32'h0;
	logic [4:0]  cnt       = 5'h00;
	logic        go        = 1'b0;
	logic        eof       = 1'b0;
	logic        drain     = 1'b0;
	logic [7:0]  nb        = 8'h10;
	logic [31:0] rdata, rdata_tx, q;
	logic [15:0] rphys;
	logic [7:0]  pw_data, pr_data, taken, last;
	logic [7:0]  eof_byte  = 8'h00;
	logic        ack, pw_valid, pw_ready, pw_eof, pr_valid, pr_ready, alarm, frdy, dreq;
	logic        pr_eof;
	int          err_total       = 0;
	int          samples_checked = 0;
	int          cyc             = 0;
	always #5 i_ref_clk = ~i_ref_clk;
	cbfc_ctrl #(.AW(4), .TX_RESET(1'b0)) dut (
		.i_ref_clk(i_ref_clk), .i_nrst(nrst), .i_fifo_base(16'h0100), .i_cs(cs),
		.i_we(we), .i_addr(addr), .i_size(size), .i_wdata(wdata), .o_rdata(rdata),
		.o_ack(ack), .i_per_wvalid(pw_valid), .o_per_wready(pw_ready),
		.i_per_wdata(pw_data), .i_per_weof(pw_eof), .o_per_rvalid(pr_valid),
		.i_per_rready(pr_ready), .o_per_rdata(pr_data), .o_per_reof(pr_eof),
		.o_alarm(alarm), .o_frame_ready(frdy), .o_dma_req(dreq), .o_rd_phys(rphys));
	cbfc_far_model far (
		.i_ref_clk(i_ref_clk), .i_nrst(nrst), .i_cnt(cnt), .i_go(go), .i_eof(eof),
		.i_drain(drain), .i_wready(pw_ready), .i_rvalid(pr_valid), .i_rdata(pr_data),
		.o_wvalid(pw_valid), .o_wdata(pw_data), .o_weof(pw_eof), .o_rready(pr_ready),
		.o_taken(taken), .o_last(last));
	// Transmit-reset twin shares the bus so its reset values can be read
	cbfc_ctrl #(.AW(4), .TX_RESET(1'b1)) dut_tx (
		.i_ref_clk(i_ref_clk), .i_nrst(nrst), .i_fifo_base(16'h0100), .i_cs(cs),
		.i_we(we), .i_addr(addr), .i_size(size), .i_wdata(wdata), .o_rdata(rdata_tx),
		.o_ack(), .i_per_wvalid(1'b0), .o_per_wready(), .i_per_wdata(8'h00),
		.i_per_weof(1'b0), .o_per_rvalid(), .i_per_rready(1'b0), .o_per_rdata(),
		.o_per_reof(), .o_alarm(), .o_frame_ready(), .o_dma_req(), .o_rd_phys());
	// Frame-end byte as the peripheral takes it
	always @(posedge i_ref_clk)
	begin
		if (pr_valid && pr_ready && pr_eof)
			eof_byte <= pr_data;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Request held until the edge that sees ack
	task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] sz,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cs    <= 1'b1;
		we    <= w;
		addr  <= a;
		size  <= sz;
		wdata <= d;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 100);
		r = rdata;
		if (n >= 100)
			chk("ack", 32'h0, 32'h1);
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(1'b1, a, SZ_LONG, d, r);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [1:0] sz, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] r;
		acc(1'b0, a, sz, 32'h0, r);
		chk($sformatf("read %h", a), r & m, e & m);
	endtask : rc
	// Oldest byte lands in the lowest lane used
	task automatic rdat(input logic [7:0] a, input logic [1:0] sz);
		logic [31:0] e;
		logic [31:0] m;
		e = 32'h0;
		m = 32'h0;
		for (int i = 0; i <= int'(sz); i++)
		begin
			e[31 - 8 * (int'(a[1:0]) + i) -: 8] = nb;
			m[31 - 8 * (int'(a[1:0]) + i) -: 8] = 8'hff;
			nb++;
		end
		rc(a, sz, e, m);
	endtask : rdat
	task automatic gap(input int n);
		cs <= 1'b0;
		repeat (n) @(posedge i_ref_clk);
	endtask : gap
	task automatic push(input logic [4:0] n, input logic e);
		cs  <= 1'b0;
		cnt <= n;
		eof <= e;
		go  <= 1'b1;
		@(posedge i_ref_clk);
		go  <= 1'b0;
	endtask : push
	// Whole run needs well under a thousand cycles
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (5) @(posedge i_ref_clk);
		nrst <= 1'b1;
		@(posedge i_ref_clk);
		rc(OFF_STATUS, SZ_LONG, 32'h1, 32'h3);
		chk("tx status", rdata_tx & 32'h3, 32'h3);
		rc(OFF_THRESH, SZ_LONG, 32'h0, '1);
		chk("tx thresh", rdata_tx, 32'h3);
		rc(OFF_READ_LOCATION_POINTER, SZ_LONG, 32'h0, '1);
		wr(OFF_THRESH, 32'h8);
		wr(OFF_CONTROL, 32'h42);
		push(5'h08, 1'b0);
		gap(20);
		chk("request", {31'h0, dreq}, 32'h1);
		rdat(8'h00, SZ_LONG);
		rc(OFF_STATUS, SZ_LONG, 32'h2, 32'h2);
		rdat(8'h03, SZ_BYTE);
		rdat(8'h02, SZ_WORD);
		gap(2);
		chk("alarm", {31'h0, alarm}, 32'h0);
		rc(OFF_READ_LOCATION_POINTER, SZ_LONG, 32'h7, '1);
		chk("phys", {16'h0, rphys}, 32'h107);
		acc(1'b0, 8'h01, SZ_LONG, 32'h0, q);
		acc(1'b0, 8'h02, SZ_TRI, 32'h0, q);
		rc(OFF_STATUS, SZ_LONG, 32'h10, 32'h10);
		wr(OFF_STATUS, 32'h0);
		rc(OFF_STATUS, SZ_LONG, 32'h10, 32'h10);
		wr(OFF_STATUS, 32'h10);
		rc(OFF_STATUS, SZ_LONG, 32'h0, 32'h10);
		wr(OFF_CONTROL, 32'h4a);
		wr(OFF_THRESH, 32'he);
		push(5'h05, 1'b1);
		rdat(8'h00, SZ_TRI);
		rc(OFF_STATUS, SZ_LONG, 32'h20, 32'h20);
		gap(6);
		chk("frame", {31'h0, frdy}, 32'h1);
		rdat(8'h00, SZ_WORD);
		gap(2);
		chk("alarm", {31'h0, alarm}, 32'h1);
		rdat(8'h03, SZ_BYTE);
		gap(2);
		chk("frame", {31'h0, frdy}, 32'h0);
		chk("alarm", {31'h0, alarm}, 32'h0);
		rc(OFF_STATUS, SZ_LONG, 32'h1, 32'h1);
		wr(OFF_CONTROL, 32'h51);
		wr(OFF_THRESH, 32'h2);
		gap(2);
		chk("alarm", {31'h0, alarm}, 32'h1);
		for (int i = 0; i < 4; i++)
			wr(OFF_DATA, 32'h20212223 + 32'h04040404 * i);
		gap(2);
		chk("alarm", {31'h0, alarm}, 32'h0);
		rc(OFF_STATUS, SZ_LONG, 32'h4, 32'h4);
		drain <= 1'b1;
		gap(40);
		chk("taken", {24'h0, taken}, 32'h10);
		chk("last", {24'h0, last}, 32'h2f);
		chk("alarm", {31'h0, alarm}, 32'h1);
		drain <= 1'b0;
		wr(OFF_CONTROL, 32'h79);
		wr(OFF_DATA, 32'h30313233);
		gap(2);
		chk("frame", {31'h0, frdy}, 32'h1);
		drain <= 1'b1;
		gap(8);
		chk("frame", {31'h0, frdy}, 32'h0);
		chk("eof byte", {24'h0, eof_byte}, 32'h33);
		chk("taken", {24'h0, taken}, 32'h14);
		rc(OFF_READ_LOCATION_POINTER, SZ_LONG, 32'h1, '1);
		wr(OFF_READ_LOCATION_POINTER, 32'hfff1);
		rc(OFF_READ_LOCATION_POINTER, SZ_LONG, 32'h1, '1);
		chk("phys", {16'h0, rphys}, 32'h101);
		tally_and_finish();
	end
endmodule : cbfc_ctrl_tb
`default_nettype wire
